// ### core/epm_pkg.sv
package epm_pkg;

    localparam int unsigned EPM_AW = 18;
    localparam int unsigned EPM_DW = 32;

    // printed offsets are indices, byte address is four times the index
    localparam logic [15:0] EPM_IDX_VALUE = 16'hF220;
    localparam logic [15:0] EPM_IDX_DIR   = 16'hF221;
    localparam logic [15:0] EPM_IDX_CON_L = 16'hF222;
    localparam logic [15:0] EPM_IDX_CON_H = 16'hF223;
    localparam logic [15:0] EPM_IDX_FN_L  = 16'hF224;
    localparam logic [15:0] EPM_IDX_FN_H  = 16'hF225;

    localparam logic [7:0] EPM_RST_REG = 8'h00;

    // pin condition codes {high bit, low bit}
    localparam logic [1:0] EPM_CON_HIZ  = 2'h0;
    localparam logic [1:0] EPM_CON_PCH  = 2'h1;
    localparam logic [1:0] EPM_CON_NCH  = 2'h2;
    localparam logic [1:0] EPM_CON_CMOS = 2'h3;

    // function select codes {high bit, low bit}
    localparam logic [1:0] EPM_FN_GPIO = 2'h0;
    localparam logic [1:0] EPM_FN_ONE  = 2'h1;
    localparam logic [1:0] EPM_FN_TWO  = 2'h2;
    localparam logic [1:0] EPM_FN_SIX  = 2'h3;

    localparam logic [2:0] EPM_PIN_SDA  = 3'h0;
    localparam logic [2:0] EPM_PIN_SCL  = 3'h1;
    localparam logic [2:0] EPM_PIN_RX   = 3'h2;
    localparam logic [2:0] EPM_PIN_TX   = 3'h3;
    localparam logic [2:0] EPM_PIN_DIN  = 3'h4;
    localparam logic [2:0] EPM_PIN_CLK  = 3'h5;
    localparam logic [2:0] EPM_PIN_DOUT = 3'h6;
    localparam logic [2:0] EPM_PIN_PWM  = 3'h7;

    // levels handed to the peripherals while their pin is not selected
    localparam logic EPM_IDLE_RX  = 1'b1;
    localparam logic EPM_IDLE_I2C = 1'b1;
    localparam logic EPM_IDLE_SSP = 1'b0;

    typedef struct packed {
        logic pwm_a;
        logic pwm_b;
        logic uart_a_tx;
        logic uart_b_tx;
        logic ssp_dout;
        logic ssp_clk_out;
        logic ssp_clk_oe;
        logic scl_low;
        logic sda_low;
    } epm_periph_in_s;

    typedef struct packed {
        logic uart_a_rx;
        logic ssp_din;
        logic ssp_clk_in;
        logic scl_in;
        logic sda_in;
    } epm_periph_out_s;

    typedef struct packed {
        logic bad;
        logic forced;
        logic od;
        logic inp;
        logic per;
        logic en;
        logic val;
    } epm_pin_ctl_s;

endpackage

// ### core/epm_port.sv
// The APB register port was decided locally.
`timescale 1ns/100ps

// Overview of operation
// - output mode: condition 00 float, 01 P-channel OD, 10 N-channel OD, 11 CMOS
// - input mode: condition 00 float, 01 pull-down, 10 pull-up, 11 float
// - direction bit 0 selects output meanings, 1 selects input meanings
// - reset clears condition and function registers: GPIO, high-impedance output
// - GPIO output pin drives the data register bit through the chosen drive type
// - reading data register returns sampled pin level for input pins
// - pin 7 function: 00 GPIO, 10 second PWM; 01 and 11 prohibited
// - pin 6 function: 00 GPIO, 10 serial data out; others prohibited
// - pin 5 function: 00 GPIO, 10 serial clock out; others prohibited
// - pin 4 function: 00 GPIO, 10 serial data in; others prohibited
// - pin 3 function: 00 GPIO, 01 UART A tx, 10 first PWM, 11 UART B tx
// - pin 2 function: 00 GPIO, 01 UART A rx, 10 serial data out; 11 prohibited
// - pin 1 function: 00 GPIO, 01 I2C clock, 10 serial clock in/out; 11 prohibited
// - pin 0 function: 00 GPIO, 01 I2C data, 10 serial data in; 11 prohibited
// - prohibited code on output pin ignores data: float or held low by drive type
// - serial or UART output function forces CMOS push-pull drive
// - function code is high register bit over low register bit at the pin position
// - condition and function pairs accept 8 and 16 bit access, all bits read/write
// - data register is 8-bit read/write, reads written value in output mode
module epm_port
    import epm_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [EPM_AW-1:0]  paddr,
    input  wire logic [EPM_DW-1:0]  pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [EPM_DW-1:0]       prdata,
    output logic                    pslverr,
    input  wire logic [7:0]         pin_in,
    output logic [7:0]              pin_out,
    output logic [7:0]              pin_oe,
    output logic [7:0]              pin_pull_up,
    output logic [7:0]              pin_pull_down,
    input  wire epm_periph_in_s     periph_in,
    output epm_periph_out_s         periph_out
);

    logic [7:0]          value_r;
    logic [7:0]          dir_r;
    logic [7:0]          con_l_r;
    logic [7:0]          con_h_r;
    logic [7:0]          fn_l_r;
    logic [7:0]          fn_h_r;
    logic [7:0]          meta_r;
    logic [7:0]          sync_r;
    logic                pready_r;
    logic [EPM_DW-1:0]   prdata_r;
    logic                pslverr_r;
    logic [7:0]          out_r;
    logic [7:0]          oe_r;
    logic [7:0]          pu_r;
    logic [7:0]          pd_r;
    epm_periph_out_s     per_out_r;
    logic                wr_go;
    logic                rd_go;
    logic [EPM_DW-1:0]   rd_nxt;
    logic                hit_nxt;

    function automatic logic at_idx(input logic [EPM_AW-1:0] a, input logic [15:0] idx);
        at_idx = (a[1:0] == 2'h0) && (a[EPM_AW-1:2] == idx);
    endfunction

    // function code of one pin, high register bit over low
    function automatic logic [1:0] fn_at(input logic [2:0] idx);
        fn_at = {fn_h_r[idx], fn_l_r[idx]};
    endfunction

    // per-pin decode of the function code into drive control
    function automatic epm_pin_ctl_s pin_ctl(
        input logic [2:0]     idx,
        input logic [1:0]     fn,
        input epm_periph_in_s p
    );
        epm_pin_ctl_s c;
        c = '0;
        if (fn != EPM_FN_GPIO) begin
            c.bad = 1'b1;
        end
        case (idx)
            EPM_PIN_PWM: begin
                if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b0, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.pwm_b};
                end
            end
            EPM_PIN_DOUT: begin
                if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b1, od: 1'b0, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.ssp_dout};
                end
            end
            EPM_PIN_CLK: begin
                if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b1, od: 1'b0, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.ssp_clk_out};
                end
            end
            EPM_PIN_DIN: begin
                if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b0, inp: 1'b1,
                          per: 1'b0, en: 1'b0, val: 1'b0};
                end
            end
            EPM_PIN_TX: begin
                c.bad = 1'b0;
                c.per = (fn != EPM_FN_GPIO);
                c.en  = 1'b1;
                c.forced = (fn == EPM_FN_ONE) || (fn == EPM_FN_SIX);
                if (fn == EPM_FN_ONE) begin
                    c.val = p.uart_a_tx;
                end else if (fn == EPM_FN_TWO) begin
                    c.val = p.pwm_a;
                end else begin
                    c.val = p.uart_b_tx;
                end
            end
            EPM_PIN_RX: begin
                if (fn == EPM_FN_ONE) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b0, inp: 1'b1,
                          per: 1'b0, en: 1'b0, val: 1'b0};
                end else if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b1, od: 1'b0, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.ssp_dout};
                end
            end
            EPM_PIN_SCL: begin
                if (fn == EPM_FN_ONE) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b1, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.scl_low};
                end else if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b1, od: 1'b0, inp: 1'b0,
                          per: 1'b1, en: p.ssp_clk_oe, val: p.ssp_clk_out};
                end
            end
            EPM_PIN_SDA: begin
                if (fn == EPM_FN_ONE) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b1, inp: 1'b0,
                          per: 1'b1, en: 1'b1, val: p.sda_low};
                end else if (fn == EPM_FN_TWO) begin
                    c = '{bad: 1'b0, forced: 1'b0, od: 1'b0, inp: 1'b1,
                          per: 1'b0, en: 1'b0, val: 1'b0};
                end
            end
            default: begin
                c.bad = 1'b1;
            end
        endcase
        pin_ctl = c;
    endfunction

    // output drive by condition code, returns {oe, out}
    // P-channel only ever drives high, N-channel only ever drives low
    function automatic logic [1:0] drive(input logic [1:0] con, input logic v);
        case (con)
            EPM_CON_HIZ:  drive = 2'h0;
            EPM_CON_PCH:  drive = {v, 1'b1};
            EPM_CON_NCH:  drive = {~v, 1'b0};
            EPM_CON_CMOS: drive = {1'b1, v};
            default:      drive = 2'h0;
        endcase
    endfunction

    // pins are asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    // one wait state keeps every bus output on a flop
    assign rd_go = psel && penable && !pready_r;
    assign wr_go = psel && penable && pready_r && pwrite;

    always_comb begin
        rd_nxt  = '0;
        hit_nxt = 1'b1;
        if (at_idx(paddr, EPM_IDX_VALUE)) begin
            rd_nxt[7:0] = (dir_r & sync_r) | (~dir_r & value_r);
        end else if (at_idx(paddr, EPM_IDX_DIR)) begin
            rd_nxt[7:0] = dir_r;
        end else if (at_idx(paddr, EPM_IDX_CON_L)) begin
            rd_nxt[15:0] = {con_h_r, con_l_r};
        end else if (at_idx(paddr, EPM_IDX_CON_H)) begin
            rd_nxt[7:0] = con_h_r;
        end else if (at_idx(paddr, EPM_IDX_FN_L)) begin
            rd_nxt[15:0] = {fn_h_r, fn_l_r};
        end else if (at_idx(paddr, EPM_IDX_FN_H)) begin
            rd_nxt[7:0] = fn_h_r;
        end else begin
            hit_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= rd_go;
        end
    end

    // unmapped or misaligned access answers with an error, never hangs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= rd_go && !hit_nxt;
        end
    end

    // read data stands only beside its answer, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (rd_go && !pwrite) begin
            prdata_r <= rd_nxt;
        end else begin
            prdata_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            value_r <= EPM_RST_REG;
            dir_r   <= EPM_RST_REG;
        end else if (wr_go && pstrb[0]) begin
            if (at_idx(paddr, EPM_IDX_VALUE)) begin
                value_r <= pwdata[7:0];
            end
            if (at_idx(paddr, EPM_IDX_DIR)) begin
                dir_r <= pwdata[7:0];
            end
        end
    end

    // the low index of each pair also takes the high byte on lane 1
    always_ff @(posedge core_clk) begin
        if (rst) begin
            con_l_r <= EPM_RST_REG;
            con_h_r <= EPM_RST_REG;
        end else if (wr_go) begin
            if (at_idx(paddr, EPM_IDX_CON_L) && pstrb[0]) begin
                con_l_r <= pwdata[7:0];
            end
            if (at_idx(paddr, EPM_IDX_CON_L) && pstrb[1]) begin
                con_h_r <= pwdata[15:8];
            end else if (at_idx(paddr, EPM_IDX_CON_H) && pstrb[0]) begin
                con_h_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fn_l_r <= EPM_RST_REG;
            fn_h_r <= EPM_RST_REG;
        end else if (wr_go) begin
            if (at_idx(paddr, EPM_IDX_FN_L) && pstrb[0]) begin
                fn_l_r <= pwdata[7:0];
            end
            if (at_idx(paddr, EPM_IDX_FN_L) && pstrb[1]) begin
                fn_h_r <= pwdata[15:8];
            end else if (at_idx(paddr, EPM_IDX_FN_H) && pstrb[0]) begin
                fn_h_r <= pwdata[7:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            epm_pin_ctl_s c;
            logic [1:0]   con;
            logic [1:0]   dv;
            logic         v;

            assign c   = pin_ctl(3'(gi), {fn_h_r[gi], fn_l_r[gi]}, periph_in);
            assign con = {con_h_r[gi], con_l_r[gi]};
            // prohibited code behaves as data 0: float or low per drive type
            assign v   = c.bad ? 1'b0 : (c.per ? c.val : value_r[gi]);
            assign dv  = drive(con, v);

            // peripheral forcing outranks both direction and condition bits
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    out_r[gi] <= 1'b0;
                    oe_r[gi]  <= 1'b0;
                    pu_r[gi]  <= 1'b0;
                    pd_r[gi]  <= 1'b0;
                end else if (c.forced) begin
                    out_r[gi] <= c.val;
                    oe_r[gi]  <= c.en;
                    pu_r[gi]  <= 1'b0;
                    pd_r[gi]  <= 1'b0;
                end else if (c.od) begin
                    out_r[gi] <= 1'b0;
                    oe_r[gi]  <= c.val;
                    pu_r[gi]  <= 1'b0;
                    pd_r[gi]  <= 1'b0;
                end else if (c.inp || dir_r[gi]) begin
                    out_r[gi] <= 1'b0;
                    oe_r[gi]  <= 1'b0;
                    pu_r[gi]  <= (con == EPM_CON_NCH);
                    pd_r[gi]  <= (con == EPM_CON_PCH);
                end else begin
                    out_r[gi] <= dv[0];
                    oe_r[gi]  <= dv[1];
                    pu_r[gi]  <= 1'b0;
                    pd_r[gi]  <= 1'b0;
                end
            end
        end
    endgenerate

    // inputs handed to the peripherals only while their function is selected
    always_ff @(posedge core_clk) begin
        if (rst) begin
            per_out_r <= '{uart_a_rx: EPM_IDLE_RX, ssp_din: EPM_IDLE_SSP, ssp_clk_in: EPM_IDLE_SSP,
                           scl_in: EPM_IDLE_I2C, sda_in: EPM_IDLE_I2C};
        end else begin
            if (fn_at(EPM_PIN_RX) == EPM_FN_ONE) begin
                per_out_r.uart_a_rx <= sync_r[EPM_PIN_RX];
            end else begin
                per_out_r.uart_a_rx <= EPM_IDLE_RX;
            end
            if (fn_at(EPM_PIN_SDA) == EPM_FN_TWO) begin
                per_out_r.ssp_din <= sync_r[EPM_PIN_SDA];
            end else if (fn_at(EPM_PIN_DIN) == EPM_FN_TWO) begin
                per_out_r.ssp_din <= sync_r[EPM_PIN_DIN];
            end else begin
                per_out_r.ssp_din <= EPM_IDLE_SSP;
            end
            if (fn_at(EPM_PIN_SCL) == EPM_FN_TWO) begin
                per_out_r.ssp_clk_in <= sync_r[EPM_PIN_SCL];
            end else begin
                per_out_r.ssp_clk_in <= EPM_IDLE_SSP;
            end
            if (fn_at(EPM_PIN_SCL) == EPM_FN_ONE) begin
                per_out_r.scl_in <= sync_r[EPM_PIN_SCL];
            end else begin
                per_out_r.scl_in <= EPM_IDLE_I2C;
            end
            if (fn_at(EPM_PIN_SDA) == EPM_FN_ONE) begin
                per_out_r.sda_in <= sync_r[EPM_PIN_SDA];
            end else begin
                per_out_r.sda_in <= EPM_IDLE_I2C;
            end
        end
    end

    assign pready        = pready_r;
    assign prdata        = prdata_r;
    assign pslverr       = pslverr_r;
    assign pin_out       = out_r;
    assign pin_oe        = oe_r;
    assign pin_pull_up   = pu_r;
    assign pin_pull_down = pd_r;
    assign periph_out    = per_out_r;

endmodule

// ### verification/epm_port_properties.sv
`timescale 1ns/100ps
module epm_port_properties
    import epm_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [EPM_AW-1:0] paddr,
    input wire logic              pready,
    input wire logic [EPM_DW-1:0] prdata,
    input wire logic              pslverr,
    input wire logic [7:0]        pin_out,
    input wire logic [7:0]        pin_oe,
    input wire logic [7:0]        pin_pull_up,
    input wire logic [7:0]        pin_pull_down,
    input wire epm_periph_in_s    periph_in
);
    default clocking cb @(posedge core_clk);
    endclocking

    wire logic wr_done = psel & penable & pready & pwrite;

    chk_ready_single: assert property (disable iff (rst) pready |=> !pready)
        else $error("pready held past one cycle");
    chk_access_two: assert property (disable iff (rst) psel && penable && !pready |=> pready)
        else $error("access phase not two cycles");
    chk_ready_cause: assert property (disable iff (rst) pready |-> $past(psel) && $past(penable))
        else $error("pready without an access");
    chk_rdata_zero: assert property (disable iff (rst) (!pready || pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    chk_align_err: assert property (disable iff (rst) pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    chk_err_ready: assert property (disable iff (rst) pslverr |-> pready)
        else $error("pslverr without pready");
    chk_reset_pins: assert property (rst |=> pin_oe == 8'h00 && pin_pull_up == 8'h00 && !pready)
        else $error("pins not released by reset");
    chk_pull_excl: assert property (disable iff (rst) (pin_pull_up & pin_pull_down) == 8'h00)
        else $error("pull-up and pull-down together");
    // pins move only two edges after a write or one edge after a peripheral change
    chk_pins_hold: assert property (disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(wr_done, 2) && $past(periph_in) == $past(periph_in, 2)
        |-> $stable(pin_oe) && $stable(pin_out) && $stable(pin_pull_up))
        else $error("pins changed without cause");
endmodule

bind epm_port epm_port_properties u_props (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .periph_in(periph_in));

// ### verification/epm_board.sv
`timescale 1ns/100ps
module epm_board (
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] pull_down,
    input  wire logic [7:0] drv_en,
    input  wire logic [7:0] drv_val,
    output logic [7:0]      pin_in
);
    // a floating line toggles so a stale level never passes for a real one
    logic [7:0] float_r = 8'h5A;
    always @(posedge core_clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (drv_en[i]) pin_in[i] = drv_val[i];
            else if (pull_up[i] | pull_down[i]) pin_in[i] = pull_up[i];
            else pin_in[i] = float_r[i];
        end
    end
endmodule

// ### verification/eight_bit_port_pad_config_mux_tb_top.sv
`timescale 1ns/100ps
module eight_bit_port_pad_config_mux_tb_top;
    import epm_pkg::*;
    logic              core_clk, rst, psel, penable, pwrite, pready, pslverr, err_r;
    logic [EPM_AW-1:0] paddr;
    logic [EPM_DW-1:0] pwdata, prdata, rd_r;
    logic [3:0]        pstrb;
    logic [7:0]        pin_in, pin_out, pin_oe, pull_up, pull_down, drv_en, drv_val;
    epm_periph_in_s    periph_in;
    epm_periph_out_s   periph_out;
    int                fails, num_checks;
    // pin[10:8] fn[7:6] cond[5:4] oe[3:2] drive[1:0]; kind 2 means peripheral level
    localparam logic [10:0] CASES [15] = '{11'h7B6, 11'h774, 11'h7D0, 11'h686, 11'h586, 11'h4B0, 11'h346,
        11'h3B6, 11'h3C6, 11'h286, 11'h270, 11'h178, 11'h18A, 11'h078, 11'h0E4};

    always #10 core_clk = ~core_clk;

    epm_port u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pull_up), .pin_pull_down(pull_down),
        .periph_in(periph_in), .periph_out(periph_out));
    epm_board u_board (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up),
        .pull_down(pull_down), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 2);
        rd_r = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] i, input logic [15:0] d, input logic [3:0] s);
        apb({i, 2'h0}, 1'b1, {16'h0, d}, s);
    endtask

    task automatic rd(input logic [15:0] i, input logic [31:0] e);
        apb({i, 2'h0}, 1'b0, 32'h0, 4'h0);
        chk(rd_r, e);
    endtask

    // registered pins: let the launching edge land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic kind(input logic [1:0] k, input logic v);
        return k == 2'h2 ? v : k[0];
    endfunction

    task automatic t_reset;
        for (int i = 0; i < 6; i++) rd(16'(EPM_IDX_VALUE + i), 32'h0);
        chk({pin_out, pin_oe, pull_up, pull_down}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs;
        wr(EPM_IDX_CON_L, 16'hA55A, 4'h3);
        rd(EPM_IDX_CON_L, 32'hA55A);
        rd(EPM_IDX_CON_H, 32'hA5);
        wr(EPM_IDX_CON_H, 16'h003C, 4'h1);
        wr(EPM_IDX_CON_L, 16'hFF11, 4'h1);
        rd(EPM_IDX_CON_L, 32'h3C11);
        wr(EPM_IDX_FN_L, 16'h5AA5, 4'h3);
        rd(EPM_IDX_FN_H, 32'h5A);
        wr(EPM_IDX_FN_L, 16'h0000, 4'h3);
        apb({EPM_IDX_CON_L, 2'h2}, 1'b1, 32'h0, 4'hF);
        chk(err_r, 1'b1);
        apb({16'hF226, 2'h0}, 1'b0, 32'h0, 4'h0);
        chk(err_r, 1'b1);
        chk(rd_r, 32'h0);
        rd(EPM_IDX_CON_L, 32'h3C11);
        wr(EPM_IDX_CON_L, 16'h0000, 4'h3);
        wr(EPM_IDX_VALUE, 16'h00A5, 4'h1);
        rd(EPM_IDX_VALUE, 32'hA5);
        $display("test regs done");
    endtask

    task automatic t_out;
        for (int c = 0; c < 4; c++) begin
            wr(EPM_IDX_CON_L, {{8{c[1]}}, {8{c[0]}}}, 4'h3);
            settle(2);
            chk(pin_oe, c == 0 ? 8'h00 : c == 1 ? 8'hA5 : c == 2 ? 8'h5A : 8'hFF);
            chk(pin_out & pin_oe, c[0] ? 8'hA5 : 8'h00);
            chk(pull_up | pull_down, 8'h00);
        end
        $display("test output modes done");
    endtask

    task automatic t_in;
        wr(EPM_IDX_DIR, 16'h00FF, 4'h1);
        for (int c = 0; c < 4; c++) begin
            wr(EPM_IDX_CON_L, {{8{c[1]}}, {8{c[0]}}}, 4'h3);
            settle(2);
            chk({pin_oe, pull_up, pull_down}, {8'h00, c == 2 ? 8'hFF : 8'h00, c == 1 ? 8'hFF : 8'h00});
        end
        @(posedge core_clk);
        drv_en <= 8'hFF;
        drv_val <= 8'h96;
        settle(3);
        rd(EPM_IDX_VALUE, 32'h96);
        wr(EPM_IDX_DIR, 16'h000F, 4'h1);
        settle(4);
        rd(EPM_IDX_VALUE, 32'hA6);
        wr(EPM_IDX_DIR, 16'h0000, 4'h1);
        wr(EPM_IDX_CON_L, 16'h0000, 4'h3); // all pins high-impedance output for analog use
        drv_en <= 8'h00;
        $display("test input modes done");
    endtask

    task automatic t_func;
        logic [2:0] p;
        logic [7:0] m;
        logic       eo;
        wr(EPM_IDX_VALUE, 16'h00FF, 4'h1);
        for (int k = 0; k < 15; k++) begin
            p = CASES[k][10:8];
            m = 8'h01 << p;
            wr(EPM_IDX_CON_L, {CASES[k][5] ? m : 8'h00, CASES[k][4] ? m : 8'h00}, 4'h3);
            wr(EPM_IDX_FN_L, {CASES[k][7] ? m : 8'h00, CASES[k][6] ? m : 8'h00}, 4'h3);
            for (int v = 0; v < 2; v++) begin
                @(posedge core_clk);
                periph_in <= v[0] ? '1 : '0;
                settle(2);
                eo = kind(CASES[k][3:2], v[0]);
                chk(pin_oe[p], eo);
                chk(pin_out[p] & eo, kind(CASES[k][1:0], v[0]) & eo);
            end
        end
        wr(EPM_IDX_CON_L, 16'h0000, 4'h3);
        $display("test functions done");
    endtask

    task automatic t_inputs;
        logic [7:0] w;
        wr(EPM_IDX_FN_L, 16'h1007, 4'h3);
        @(posedge core_clk);
        periph_in <= '0;
        drv_en <= 8'hFF;
        for (int i = 0; i < 4; i++) begin
            // pins 0, 1 and 4 on serial inputs: pin 0 must win over pin 4
            if (i == 2) wr(EPM_IDX_FN_L, 16'h1300, 4'h3);
            w = i == 0 ? 8'h17 : i == 1 ? 8'hE8 : i == 2 ? 8'h12 : 8'h0D;
            @(posedge core_clk);
            drv_val <= w;
            settle(4);
            if (i < 2) chk(periph_out, {w[2], w[4], 1'b0, w[1], w[0]});
            else chk(periph_out, {1'b1, w[0], w[1], 2'b11});
        end
        wr(EPM_IDX_FN_L, 16'h0000, 4'h3);
        settle(4);
        chk(periph_out, 5'h13);
        $display("test peripheral inputs done");
    endtask

    initial begin
        repeat (6000) @(posedge core_clk);
        fails++;
        $display("watchdog expired at %0t", $time);
        end_sim();
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        periph_in = '0;
        drv_en = 8'h00;
        drv_val = 8'h00;
        fails = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_regs();
        t_out();
        t_in();
        t_func();
        t_inputs();
        end_sim();
    end
endmodule
